// [rtl/serial_instruction_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_instruction_sequencer
    import seq_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    output logic                   mem_sel_o,
    output logic                   mem_we_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic [WORD_W:0]        mem_wdata_o,
    input  wire logic [WORD_W:0]   mem_rdata_i,
    input  wire logic              auto_req_i,
    input  wire logic              auto_we_i,
    input  wire logic [ADDR_W-1:0] auto_addr_i,
    input  wire logic [WORD_W-1:0] auto_wdata_i,
    output logic                   auto_done_o,
    output logic [WORD_W-1:0]      auto_rdata_o,
    output logic                   ser_bit_o,
    output logic                   ser_valid_o,
    output logic                   io_rd_o,
    output logic                   io_wr_o,
    output logic                   disc_rd_o,
    output logic                   disc_wr_o,
    output logic [AF_W-1:0]        io_addr_o,
    output logic [WORD_W-1:0]      io_wdata_o,
    input  wire logic [WORD_W-1:0] io_rdata_i,
    input  wire logic              disc_i,
    output logic                   parity_err_o,
    output logic [ADDR_W-1:0]      ic_o
);
    function automatic logic par_f(input logic [WORD_W-1:0] w);
        par_f = ~^w;
    endfunction : par_f

    st_type            st_q;
    st_type            st_d;
    st_type            dec_next;
    st_type            mem_next;
    seg_type           seg;
    logic [WORD_W-1:0] ibuf_q;
    logic              seg_sel_q;
    logic [ADDR_W-1:0] ic_q;
    logic [ADDR_W-1:0] mar_q;
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] base;
    logic [WORD_W-1:0] acc_q;
    logic [WORD_W-1:0] ext_q;
    logic [WORD_W-1:0] mdr_q;
    logic [WORD_W-1:0] hold_q;
    logic              carry_q;
    logic [AF_W-1:0]   cc_q;
    logic [AF_W-1:0]   ioar_q;
    logic              mact_q;
    logic              mown_q;
    logic [4:0]        mcnt_q;
    logic              main_req;
    logic              mstart;
    logic              mlast;
    logic              main_done;
    logic              mem_op;
    logic              ar_op;
    logic              jmp_op;
    logic              io_op;
    logic              din_op;
    logic              taken;
    logic              tick;
    logic              ser_busy;
    logic              a_bit;
    logic              b_bit;
    logic              sum;
    logic              cout;

    // First-coded segment sits in the low half of the word
    assign seg = seg_type'(seg_sel_q ? ibuf_q[SEG1_LSB +: SEG_W]
                                     : ibuf_q[SEG0_LSB +: SEG_W]);

    assign ar_op  = seg.op inside {OP_LDA, OP_ADD, OP_SUB};
    assign mem_op = ar_op || seg.op inside {OP_STO, OP_TRI, OP_XLD};
    assign jmp_op = seg.op inside {OP_JMP, OP_JAZ, OP_JAN};
    assign din_op = (seg.op == OP_INPUT_TRANSFER_INSTR);
    assign io_op  = din_op || seg.op inside {OP_DOUT, OP_DSI, OP_DSO};
    assign taken  = (seg.op == OP_JMP)
                 || (seg.op == OP_JAZ && acc_q == ACC_RST)
                 || (seg.op == OP_JAN && acc_q[WORD_W-1]);

    // Jumps are relative to the counter, table reads offset from the table
    assign base = jmp_op ? ic_q : (seg.op == OP_TRI) ? TT_BASE : IC_RST;

    index_unit u_index (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .sel_i    (seg.xr),
        .af_i     (seg.af),
        .base_i   (base),
        .upd_i    ((st_q == ST_DEC && seg.op == OP_XAD) ||
                   (st_q == ST_MEM && main_done && seg.op == OP_XLD)),
        .ld_i     (seg.op == OP_XLD),
        .ld_val_i (mem_rdata_i[ADDR_W-1:0]),
        .ea_o     (ea)
    );

    ser_unit u_ser (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .load_i  (st_q == ST_LD),
        .word_i  (mdr_q),
        .tick_o  (tick),
        .bit_o   (ser_bit_o),
        .valid_o (ser_valid_o),
        .busy_o  (ser_busy)
    );

    assign dec_next = (seg.op == OP_STO)       ? ST_HOLD  :
                      mem_op                    ? ST_MEM   :
                      taken                     ? ST_FETCH :
                      (seg.op == OP_SHR)        ? ST_SHF   :
                      (din_op && seg_sel_q)     ? ST_NEXT  :
                      io_op                     ? ST_IO    : ST_NEXT;
    assign mem_next = ar_op ? ST_LD : (seg.op == OP_TRI) ? ST_FETCH : ST_NEXT;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_FETCH: if (main_done) st_d = ST_DEC;
            ST_DEC:   st_d = dec_next;
            ST_MEM:   if (main_done) st_d = mem_next;
            ST_LD:    st_d = ST_SER;
            ST_SER:   if (ser_valid_o && !ser_busy) st_d = ST_NEXT;
            ST_HOLD:  st_d = ST_MEM;
            ST_SHF:   if (cc_q == 9'h000) st_d = ST_NEXT;
            ST_IO:    st_d = ST_NEXT;
            ST_NEXT:  st_d = seg_sel_q ? ST_FETCH : ST_DEC;
            default:  st_d = ST_FETCH;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) st_q <= ST_FETCH;
        else         st_q <= st_d;
    end

    // Memory cycle engine: main program first, spare cycles to auto I/O
    assign main_req  = (st_q == ST_FETCH) || (st_q == ST_MEM);
    assign mstart    = !mact_q && (main_req || (auto_req_i && !auto_done_o));
    assign mlast     = mact_q && (mcnt_q == 5'(MEM_CYC - 1));
    assign main_done = mlast && !mown_q;
    assign mem_sel_o = mact_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mact_q      <= 1'b0;
            mown_q      <= 1'b0;
            mcnt_q      <= 5'h00;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= IC_RST;
            mem_wdata_o <= 32'h00000000;
        end else if (mstart) begin
            mact_q      <= 1'b1;
            mown_q      <= !main_req;
            mcnt_q      <= 5'h00;
            mem_we_o    <= main_req ? (st_q == ST_MEM && seg.op == OP_STO) : auto_we_i;
            mem_addr_o  <= main_req ? mar_q : auto_addr_i;
            mem_wdata_o <= main_req ? {par_f(hold_q), hold_q}
                                    : {par_f(auto_wdata_i), auto_wdata_i};
        end else if (mlast) begin
            mact_q <= 1'b0;
        end else if (mact_q) begin
            mcnt_q <= mcnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            auto_done_o  <= 1'b0;
            auto_rdata_o <= ACC_RST;
            parity_err_o <= 1'b0;
        end else begin
            auto_done_o  <= mlast && mown_q;
            parity_err_o <= mlast && !mem_we_o && (^mem_rdata_i != 1'b1);
            if (mlast && mown_q) auto_rdata_o <= mem_rdata_i[WORD_W-1:0];
        end
    end

    // Program sequencing
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ibuf_q    <= ACC_RST;
            seg_sel_q <= 1'b0;
            ic_q      <= IC_RST;
            mar_q     <= IC_RST;
        end else begin
            if (st_q == ST_FETCH && main_done) begin
                ibuf_q    <= mem_rdata_i[WORD_W-1:0];
                seg_sel_q <= 1'b0;
            end
            if (st_q == ST_DEC && mem_op) mar_q <= ea;
            // No return link kept; software stores the counter
            if (st_q == ST_DEC && taken) begin
                ic_q  <= ea;
                mar_q <= ea;
            end
            if (st_q == ST_MEM && main_done && seg.op == OP_TRI) begin
                ic_q  <= mem_rdata_i[ADDR_W-1:0];
                mar_q <= mem_rdata_i[ADDR_W-1:0];
            end
            if (st_q == ST_NEXT) begin
                seg_sel_q <= !seg_sel_q;
                if (seg_sel_q) begin
                    ic_q  <= ic_q + 15'h0001;
                    mar_q <= ic_q + 15'h0001;
                end
            end
        end
    end
    assign ic_o = ic_q;

    // Serial adder; loads treat the accumulator side as zero
    assign a_bit = (seg.op == OP_LDA) ? 1'b0 : acc_q[0];
    assign b_bit = ser_bit_o ^ (seg.op == OP_SUB);
    assign sum   = a_bit ^ b_bit ^ carry_q;
    assign cout  = (a_bit & b_bit) | (carry_q & (a_bit ^ b_bit));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_q   <= ACC_RST;
            ext_q   <= ACC_RST;
            carry_q <= 1'b0;
        end else begin
            if (st_q == ST_LD) carry_q <= (seg.op == OP_SUB);
            if (st_q == ST_SER && ser_valid_o) begin
                acc_q   <= {sum, acc_q[WORD_W-1:1]};
                carry_q <= cout;
            end
            // Extension only ever fed from the accumulator
            if (st_q == ST_SHF && tick && cc_q != 9'h000) begin
                acc_q <= {acc_q[WORD_W-1], acc_q[WORD_W-1:1]};
                ext_q <= {acc_q[0], ext_q[WORD_W-1:1]};
            end
            if (st_q == ST_IO && din_op) acc_q <= io_rdata_i;
            if (st_q == ST_IO && seg.op == OP_DSI) acc_q <= {30'h00000000, disc_i};
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mdr_q  <= ACC_RST;
            hold_q <= ACC_RST;
        end else begin
            if (st_q == ST_DEC && seg.op == OP_STO) mdr_q <= acc_q;
            else if (main_done) mdr_q <= mem_rdata_i[WORD_W-1:0];
            if (st_q == ST_HOLD) hold_q <= mdr_q;
        end
    end

    // Control counter and I/O address register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cc_q   <= 9'h000;
            ioar_q <= 9'h000;
        end else if (st_q == ST_DEC && (io_op || seg.op == OP_SHR)) begin
            cc_q   <= seg.af;
            ioar_q <= (seg.op inside {OP_DSI, OP_DSO}) ? seg.af
                                                        : AF_W'(seg.af[DIO_W-1:0]);
        end else if (st_q == ST_SHF && tick && cc_q != 9'h000) begin
            cc_q <= cc_q - 9'h001;
        end
    end

    assign io_addr_o  = ioar_q;
    assign io_wdata_o = acc_q;
    assign io_rd_o    = (st_q == ST_IO) && din_op;
    assign io_wr_o    = (st_q == ST_IO) && (seg.op == OP_DOUT);
    assign disc_rd_o  = (st_q == ST_IO) && (seg.op == OP_DSI);
    assign disc_wr_o  = (st_q == ST_IO) && (seg.op == OP_DSO);

    property p_memlen;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(mem_sel_o) |-> mem_sel_o[*8] ##22 mem_sel_o ##1 !mem_sel_o;
    endproperty
    a_memlen: assert property (p_memlen) else $error("memory cycle length wrong");

    property p_seg2;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_NEXT && !seg_sel_q) |=> (st_q == ST_DEC && seg_sel_q);
    endproperty
    a_seg2: assert property (p_seg2) else $error("second segment not run");

    property p_nextpair;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_NEXT && seg_sel_q) |=>
            (ic_o == $past(ic_o) + 15'h0001) && st_q == ST_FETCH && mar_q == ic_o;
    endproperty
    a_nextpair: assert property (p_nextpair) else $error("next pair address wrong");

    property p_skip;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_DEC && !seg_sel_q && taken && !mem_op) |=>
            st_q == ST_FETCH ##1 (!seg_sel_q) [*1];
    endproperty
    a_skip: assert property (p_skip) else $error("second segment not skipped");

    property p_tri;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_MEM && main_done && seg.op == OP_TRI) |=>
            ic_o == $past(mem_rdata_i[ADDR_W-1:0]) && mar_q == ic_o;
    endproperty
    a_tri: assert property (p_tri) else $error("table word not loaded");

    property p_ea;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_DEC && mem_op) |=> mar_q == $past(ea);
    endproperty
    a_ea: assert property (p_ea) else $error("effective address not taken");

    property p_auto;
        @(posedge clk_i) disable iff (!rstn_i)
        (main_req && !mact_q && auto_req_i) |=> (mem_sel_o && !mown_q);
    endproperty
    a_auto: assert property (p_auto) else $error("auto cycle took main slot");

    property p_din;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_DEC && seg_sel_q && din_op) |=> st_q == ST_NEXT ##1 !io_rd_o;
    endproperty
    a_din: assert property (p_din) else $error("input transfer in second segment");

    property p_serial;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_LD) |-> ##[120:132] (st_q == ST_NEXT);
    endproperty
    a_serial: assert property (p_serial) else $error("serial operand move late");

    property p_resume;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ST_FETCH && main_done) |=> st_q == ST_DEC && !seg_sel_q;
    endproperty
    a_resume: assert property (p_resume) else $error("pair not started at first segment");

    c_skip:  cover property (@(posedge clk_i) disable iff (!rstn_i)
                             st_q == ST_DEC && !seg_sel_q && taken);
    c_tri:   cover property (@(posedge clk_i) disable iff (!rstn_i)
                             st_q == ST_MEM && main_done && seg.op == OP_TRI);
    c_auto:  cover property (@(posedge clk_i) disable iff (!rstn_i) auto_done_o);
    c_shift: cover property (@(posedge clk_i) disable iff (!rstn_i)
                             st_q == ST_SHF && cc_q == 9'h001);
endmodule : serial_instruction_sequencer
`default_nettype wire

// [rtl/seq_pkg.sv]
package seq_pkg;
    localparam int WORD_W    = 31;
    localparam int SEG_W     = 15;
    localparam int ADDR_W    = 15;
    localparam int AF_W      = 9;
    localparam int DIO_W     = 8;
    localparam int SEG0_LSB  = 0;
    localparam int SEG1_LSB  = 15;
    localparam int CLK_PS    = 100000;
    localparam int MEMCYC_PS = 3000000;
    localparam int MEM_CYC   = MEMCYC_PS / CLK_PS;
    localparam int BIT_PS    = 325521;
    localparam int BIT_CYC   = (BIT_PS + CLK_PS - 1) / CLK_PS;
    localparam logic [ADDR_W-1:0] TT_BASE = 15'h7E00;
    localparam logic [ADDR_W-1:0] IC_RST  = 15'h0000;
    localparam logic [WORD_W-1:0] ACC_RST = 31'h00000000;

    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_LDA  = 4'h1,
        OP_STO  = 4'h2,
        OP_ADD  = 4'h3,
        OP_SUB  = 4'h4,
        OP_JMP  = 4'h5,
        OP_JAZ  = 4'h6,
        OP_JAN  = 4'h7,
        OP_TRI  = 4'h8,
        OP_XAD  = 4'h9,
        OP_XLD  = 4'hA,
        OP_SHR  = 4'hB,
        OP_INPUT_TRANSFER_INSTR = 4'hC,
        OP_DOUT = 4'hD,
        OP_DSI  = 4'hE,
        OP_DSO  = 4'hF
    } op_type;

    typedef struct packed {
        op_type          op;
        logic [1:0]      xr;
        logic [AF_W-1:0] af;
    } seg_type;

    typedef enum logic [8:0] {
        ST_FETCH = 9'h001,
        ST_DEC   = 9'h002,
        ST_MEM   = 9'h004,
        ST_LD    = 9'h008,
        ST_SER   = 9'h010,
        ST_HOLD  = 9'h020,
        ST_SHF   = 9'h040,
        ST_IO    = 9'h080,
        ST_NEXT  = 9'h100
    } st_type;
endpackage : seq_pkg

// [rtl/ser_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module ser_unit
    import seq_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              load_i,
    input  wire logic [WORD_W-1:0] word_i,
    output logic                   tick_o,
    output logic                   bit_o,
    output logic                   valid_o,
    output logic                   busy_o
);
    logic [2:0]        div_q;
    logic [WORD_W-1:0] sh_q;
    logic [4:0]        n_q;

    // Free-running bit clock, so shifts and serial moves share one rate
    assign tick_o = (div_q == 3'(BIT_CYC - 1));
    assign busy_o = (n_q != 5'h00);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= 3'h0;
        end else begin
            div_q <= tick_o ? 3'h0 : div_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_q    <= ACC_RST;
            n_q     <= 5'h00;
            bit_o   <= 1'b0;
            valid_o <= 1'b0;
        end else if (load_i) begin
            sh_q    <= word_i;
            n_q     <= 5'(WORD_W);
            valid_o <= 1'b0;
        end else if (tick_o && busy_o) begin
            bit_o   <= sh_q[0];
            sh_q    <= {1'b0, sh_q[WORD_W-1:1]};
            n_q     <= n_q - 5'h01;
            valid_o <= 1'b1;
        end else begin
            valid_o <= 1'b0;
        end
    end
endmodule : ser_unit
`default_nettype wire

// [rtl/index_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module index_unit
    import seq_pkg::*;
(
    input  wire logic [1:0]        sel_i,
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [AF_W-1:0]   af_i,
    input  wire logic [ADDR_W-1:0] base_i,
    input  wire logic              upd_i,
    input  wire logic              ld_i,
    input  wire logic [ADDR_W-1:0] ld_val_i,
    output logic      [ADDR_W-1:0] ea_o
);
    logic [ADDR_W-1:0] xr_q [3];
    logic [ADDR_W-1:0] xr_sel;

    // Tag zero means no indexing
    assign xr_sel = (sel_i == 2'h1) ? xr_q[0] :
                    (sel_i == 2'h2) ? xr_q[1] :
                    (sel_i == 2'h3) ? xr_q[2] : IC_RST;
    assign ea_o   = base_i + ADDR_W'(af_i) + xr_sel;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 3; i++) xr_q[i] <= IC_RST;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (upd_i && sel_i == 2'(i + 1)) begin
                    xr_q[i] <= ld_i ? ld_val_i : xr_q[i] + ADDR_W'(af_i);
                end
            end
        end
    end
endmodule : index_unit
`default_nettype wire

// [dv/mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import seq_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              mem_sel_i,
    input  wire logic              mem_we_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    input  wire logic [WORD_W:0]   mem_wdata_i,
    output logic      [WORD_W:0]   mem_rdata_o
);
    logic [WORD_W:0] mem [0:32767];
    logic [WORD_W:0] last_q = '0;
    // Idle bus shows the inverted last word, so a stale read never matches
    assign mem_rdata_o = mem_sel_i ? mem[mem_addr_i] : ~last_q;
    always @(posedge clk_i) begin
        if (mem_sel_i) begin
            last_q <= mem[mem_addr_i];
            if (mem_we_i) begin
                mem[mem_addr_i] <= mem_wdata_i;
            end
        end
    end
endmodule : mem_model
`default_nettype wire

// [dv/tb_serial_instruction_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_serial_instruction_sequencer
    import seq_pkg::*;
;
    logic clk_i, rstn_i, sel, we, a_req, a_we, a_done, sbit, sval, rd, wr, drd, dwr, disc, perr;
    logic [ADDR_W-1:0] addr, a_addr, ic;
    logic [WORD_W:0]   wd, rdat;
    logic [WORD_W-1:0] a_wd, a_rd, iow, ior;
    logic [AF_W-1:0]   ioa, rd_a, wr_a, dr_a, dw_a;
    logic [WORD_W-1:0] wr_d, dw_d, ser_w;
    logic [15:0]       cyc_q[$];
    logic              sel_d = 1'b0;
    int len = 0, n_rd = 0, n_wr = 0, n_perr = 0, errors = 0, n_compared = 0;

    serial_instruction_sequencer dut (.clk_i(clk_i), .rstn_i(rstn_i), .mem_sel_o(sel),
        .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wd), .mem_rdata_i(rdat),
        .auto_req_i(a_req), .auto_we_i(a_we), .auto_addr_i(a_addr), .auto_wdata_i(a_wd),
        .auto_done_o(a_done), .auto_rdata_o(a_rd), .ser_bit_o(sbit), .ser_valid_o(sval),
        .io_rd_o(rd), .io_wr_o(wr), .disc_rd_o(drd), .disc_wr_o(dwr), .io_addr_o(ioa),
        .io_wdata_o(iow), .io_rdata_i(ior), .disc_i(disc), .parity_err_o(perr), .ic_o(ic));
    mem_model mem_i (.clk_i(clk_i), .mem_sel_i(sel), .mem_we_i(we), .mem_addr_i(addr),
        .mem_wdata_i(wd), .mem_rdata_o(rdat));

    always #50 clk_i = ~clk_i;

    function automatic logic [WORD_W:0] par(input logic [WORD_W-1:0] d);
        return {~^d, d};
    endfunction : par

    function automatic seg_type sg(input op_type o, input logic [1:0] x, input logic [8:0] a);
        return seg_type'{o, x, a};
    endfunction : sg

    task automatic results();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    always @(posedge clk_i) begin
        if (sel && !sel_d)
            cyc_q.push_back({we, addr});
        if (sel)
            len = len + 1;
        else if (sel_d) begin
            cmp("cycle_length", 32'd30, len);
            len = 0;
        end
        sel_d = sel;
        if (rd) begin n_rd++; rd_a = ioa; end
        if (wr) begin n_wr++; wr_a = ioa; wr_d = iow; end
        if (drd) dr_a = ioa;
        if (dwr) begin dw_a = ioa; dw_d = iow; end
        if (perr) n_perr++;
        if (sval) ser_w = {sbit, ser_w[WORD_W-1:1]};
    end

    // Next memory cycle start, as {write, address}
    task automatic cyc(input logic w, input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        while (cyc_q.size() == 0) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 300) begin
                errors++;
                $display("CHECK FAILED cycle expected %h seen none", a);
                results();
            end
        end
        cmp("cycle", {w, a}, cyc_q.pop_front());
    endtask : cyc

    task automatic seq_run();
        cyc(1'b0, 15'h0000);
        cyc(1'b0, 15'h0001);
        cyc(1'b0, 15'h0002);
        cyc(1'b0, 15'h7E03);
        cyc(1'b0, 15'h0010);
        cmp("skipped_out", 32'd0, n_wr);
    endtask : seq_run

    task automatic io_run();
        cyc(1'b0, 15'h0011);
        cmp("in_count", 32'd1, n_rd);
        cmp("in_addr", 32'h005, rd_a);
        cmp("out_count", 32'd1, n_wr);
        cmp("out_addr", 32'h02A, wr_a);
        cmp("out_data", 32'h12345678, wr_d);
        cyc(1'b0, 15'h0012);
        cmp("dsi_addr", 32'h1FF, dr_a);
        cmp("dso_addr", 32'h100, dw_a);
        cmp("dso_bit", 32'h1, dw_d);
    endtask : io_run

    task automatic idx_run();
        cyc(1'b1, 15'h0030);
        cyc(1'b0, 15'h0013);
        cmp("stored", par(31'h1), mem_i.mem[15'h0030]);
        cyc(1'b0, 15'h7E04);
        cyc(1'b0, 15'h0020);
    endtask : idx_run

    task automatic alu_run();
        cyc(1'b0, 15'h0031);
        cyc(1'b0, 15'h0031);
        cyc(1'b0, 15'h0021);
        cyc(1'b0, 15'h0032);
        cyc(1'b0, 15'h0022);
        cmp("sub_data", 32'h7FFFFFFF, wr_d);
        cmp("sub_addr", 32'h007, wr_a);
        cyc(1'b0, 15'h0025);
        cmp("jump_ic", 32'h0025, ic);
        cmp("jump_skip", 32'd2, n_wr);
        cyc(1'b0, 15'h0033);
        cyc(1'b0, 15'h0026);
        cmp("ser_word", 32'h100, ser_w);
        cyc(1'b0, 15'h0027);
        cmp("shift_data", 32'h10, wr_d);
        cmp("shift_addr", 32'h0AB, wr_a);
        cyc(1'b0, 15'h0034);
        cyc(1'b1, 15'h0778);
        cyc(1'b0, 15'h0028);
        cmp("idx_store", par(31'h10), mem_i.mem[15'h0778]);
        cyc(1'b0, 15'h0028);
    endtask : alu_run

    // One automatic cycle, request held through the done pulse
    task automatic auto_cyc(input logic w, input logic [ADDR_W-1:0] a,
                            input logic [WORD_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        a_req <= 1'b1;
        a_we <= w;
        a_addr <= a;
        a_wd <= d;
        while (a_done !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 400) begin
                errors++;
                $display("CHECK FAILED auto_done expected 1 seen 0");
                results();
            end
        end
        @(posedge clk_i);
        a_req <= 1'b0;
    endtask : auto_cyc

    task automatic auto_run();
        auto_cyc(1'b0, 15'h0030, 31'h0);
        cmp("auto_rdata", 32'h1, a_rd);
        auto_cyc(1'b1, 15'h0035, 31'h2A);
        cmp("auto_store", par(31'h2A), mem_i.mem[15'h0035]);
        cmp("parity_err", 32'd0, n_perr);
    endtask : auto_run

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        a_req = 1'b0;
        a_we = 1'b0;
        a_addr = '0;
        a_wd = '0;
        ior = 31'h12345678;
        disc = 1'b1;
        mem_i.mem[15'h0000] = par({1'b0, sg(OP_NOP, 2'h0, 9'h0), sg(OP_NOP, 2'h0, 9'h0)});
        mem_i.mem[15'h0001] = mem_i.mem[15'h0000];
        mem_i.mem[15'h0002] = par({1'b0, sg(OP_DOUT, 2'h0, 9'h02A), sg(OP_TRI, 2'h0, 9'h003)});
        mem_i.mem[15'h7E03] = par(31'h10);
        // Input transfer kept in the first segment
        mem_i.mem[15'h0010] = par({1'b0, sg(OP_DOUT, 2'h0, 9'h02A),
                                   sg(OP_INPUT_TRANSFER_INSTR, 2'h0, 9'h005)});
        mem_i.mem[15'h0011] = par({1'b0, sg(OP_DSO, 2'h0, 9'h100), sg(OP_DSI, 2'h0, 9'h1FF)});
        mem_i.mem[15'h0012] = par({1'b0, sg(OP_STO, 2'h1, 9'h010), sg(OP_XAD, 2'h1, 9'h020)});
        mem_i.mem[15'h0013] = par({1'b0, sg(OP_NOP, 2'h0, 9'h0), sg(OP_TRI, 2'h0, 9'h004)});
        mem_i.mem[15'h7E04] = par(31'h20);
        mem_i.mem[15'h0030] = par(31'h5);
        mem_i.mem[15'h0020] = par({1'b0, sg(OP_ADD, 2'h0, 9'h031), sg(OP_LDA, 2'h0, 9'h031)});
        mem_i.mem[15'h0021] = par({1'b0, sg(OP_DOUT, 2'h0, 9'h007), sg(OP_SUB, 2'h0, 9'h032)});
        mem_i.mem[15'h0022] = par({1'b0, sg(OP_DOUT, 2'h0, 9'h008), sg(OP_JAN, 2'h0, 9'h003)});
        mem_i.mem[15'h0025] = par({1'b0, sg(OP_SHR, 2'h0, 9'h004), sg(OP_LDA, 2'h0, 9'h033)});
        mem_i.mem[15'h0026] = par({1'b0, sg(OP_DOUT, 2'h0, 9'h0AB), sg(OP_JAZ, 2'h0, 9'h001)});
        mem_i.mem[15'h0027] = par({1'b0, sg(OP_STO, 2'h2, 9'h001), sg(OP_XLD, 2'h2, 9'h034)});
        mem_i.mem[15'h0028] = par({1'b0, sg(OP_JMP, 2'h0, 9'h000), sg(OP_NOP, 2'h0, 9'h000)});
        mem_i.mem[15'h0031] = par(31'h6);
        mem_i.mem[15'h0032] = par(31'hD);
        mem_i.mem[15'h0033] = par(31'h100);
        mem_i.mem[15'h0034] = par(31'h777);
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        seq_run();
        io_run();
        idx_run();
        alu_run();
        auto_run();
        results();
    end
endmodule : tb_serial_instruction_sequencer
`default_nettype wire
